/* File: inc/pm_event_pkg.sv */
/*
 * Constants, register map and carrier types for the power-management
 * system-event enable block.
 * Assumes a 32-bit Avalon-MM slave with byte addresses and 8-bit registers
 * sitting in the low byte of each word.
 */
package pm_event_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;
    localparam int IDX_W  = 8;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] RESUME_CONTROL_2_INDEX       = 8'hcd;
    localparam logic [IDX_W-1:0] GENERAL_OUTPUT_CONTROL_INDEX = 8'hce;
    localparam logic [IDX_W-1:0] SYSTEM_EVENT_ENABLE_0_INDEX  = 8'hd0;
    localparam logic [IDX_W-1:0] SYSTEM_EVENT_ENABLE_1_INDEX  = 8'hd1;
    localparam logic [IDX_W-1:0] SYSTEM_EVENT_ENABLE_2_INDEX  = 8'hd2;
    localparam logic [IDX_W-1:0] AUX_CONTROL_INDEX            = 8'hf0;
    localparam logic [IDX_W-1:0] GLOBAL_MGMT_IRQ_STATUS_INDEX = 8'hf1;
    localparam logic [IDX_W-1:0] IRQ_STATUS_INDEX             = 8'hf2;
    localparam logic [IDX_W-1:0] IRQ_CLEAR_INDEX              = 8'hf3;
    localparam logic [IDX_W-1:0] IRQ_ENABLE_INDEX             = 8'hf4;

    // Reset values
    localparam logic [REG_W-1:0] RESUME_CONTROL_2_RESET       = 8'h00;
    localparam logic [REG_W-1:0] GENERAL_OUTPUT_CONTROL_RESET = 8'h3f;
    localparam logic [REG_W-1:0] SYSTEM_EVENT_ENABLE_RESET    = 8'h00;
    localparam logic [REG_W-1:0] AUX_CONTROL_RESET            = 8'h00;

    // Writable bits; reserved bits read as zero
    localparam logic [REG_W-1:0] RESUME_CONTROL_2_BITS        = 8'h01;
    localparam logic [REG_W-1:0] GENERAL_OUTPUT_CONTROL_BITS  = 8'h3f;
    localparam logic [REG_W-1:0] SYSTEM_EVENT_ENABLE_0_BITS   = 8'hfb;
    localparam logic [REG_W-1:0] SYSTEM_EVENT_ENABLE_1_BITS   = 8'hdf;
    localparam logic [REG_W-1:0] SYSTEM_EVENT_ENABLE_2_BITS   = 8'hfb;
    localparam logic [REG_W-1:0] AUX_CONTROL_BITS             = 8'h1f;

    // Field positions
    localparam int EXT_MGMT_RESUME_MASK_BIT = 0;
    localparam int DISK_OUT_BIT             = 5;
    localparam int RTC_ALE_BIT              = 4;
    localparam int NUM_GENERAL_OUTPUTS      = 6;
    localparam int EVENT_MASTER_EN_BIT      = 0;
    localparam int SERIAL_RING_INDICATE_EVENT_EN_BIT       = 1;
    localparam int INTR_EVENT_EN_BIT        = 3;
    localparam int NMI_EVENT_EN_BIT         = 4;
    localparam int SMI_EVENT_EN_BIT         = 5;
    localparam int EXT_MGMT_EVENT_EN_BIT    = 6;
    localparam int HW_SUSPEND_EVENT_EN_BIT  = 7;
    localparam int DISK_OE_SELECT_BIT       = 0;
    localparam int RTC_ALE_SELECT_BIT       = 1;
    localparam int MISC_BATTERY_EN_BIT      = 2;
    localparam int MISC_BUTTON_EN_BIT       = 3;
    localparam int SYSTEM_EXT_MGMT_EN_BIT   = 4;
    localparam int CAUSE_FLAG_BIT           = 7;

    // Event source vector layout
    localparam int NUM_IRQ_LINES   = 16;
    localparam int SRC_SERIAL_RING_INDICATE       = 16;
    localparam int SRC_INTR        = 17;
    localparam int SRC_NMI         = 18;
    localparam int SRC_SMI         = 19;
    localparam int SRC_EXT_MGMT    = 20;
    localparam int SRC_BATTERY     = 21;
    localparam int SRC_BUTTON      = 22;
    localparam int NUM_SOURCES     = 23;

    // Interrupt status layout
    localparam int IRQ_EVENT_SYSTEM = 0;
    localparam int IRQ_EVENT_RESUME = 1;
    localparam int NUM_IRQ_EVENTS   = 2;

    typedef struct packed {
        logic [NUM_IRQ_LINES-1:0] irq_lines;
        logic                     intr;
        logic                     nmi;
        logic                     mgmt_irq_out_n;
        logic                     ext_mgmt_irq_in_n;
        logic                     battery_low_in_n;
        logic                     suspend_button_in_n;
        logic                     serial_ring_indicate_n;
    } event_sources_type;

endpackage

/* File: design/rise_detect.sv */
/*
 * Rising-edge detector for a vector of levels, one pulse per bit.
 * Assumes inputs synchronous to clock; rst_n synchronous, active low.
 */
`timescale 1ns/1ps
module rise_detect #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] previous;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            previous <= '0;
        end else begin
            previous <= level;
        end
    end

    assign rise = level & ~previous;
endmodule // rise_detect

/* File: design/sticky_status.sv */
/*
 * Sticky event status with write-one-to-clear and enable gating onto one
 * level interrupt. Assumes set and clear come from the same clock domain.
 */
`timescale 1ns/1ps
module sticky_status #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic             clear_we,
    input  wire logic [WIDTH-1:0] clear_bits,
    input  wire logic [WIDTH-1:0] enable,
    output logic      [WIDTH-1:0] status,
    output logic                  irq
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            status <= '0;
        end else begin
            // Set wins over a clear in the same cycle
            status <= (status & ~(clear_we ? clear_bits : '0)) | set;
        end
    end

    assign irq = |(status & enable);
endmodule // sticky_status

/* File: design/pm_system_event_enable.sv */
/*
 * Power-management system-event enable registers, general output pins and
 * the system-event reload pulse, behind an Avalon-MM slave with waitrequest.
 * Assumes all event sources and alternate pin functions are synchronous to
 * clock; the timers, suspend sequencing and SMI generation live outside.
 */
// Summary of operation
// - Resume mask bit set: external management interrupt input causes no resume.
// - Each general output bit drives its pin level directly, except pins 5 and 4 when their alternate function is selected.
// - Pin 5 in disk output enable mode ignores bit 5 writes.
// - Pin 4 in RTC address latch mode ignores bit 4 writes.
// - Enable register 0 bits 0,1,3-7 qualify IRQ of same number; bit 2 reserved.
// - Enable register 1 bits 0-4 qualify IRQ8-12, bits 6,7 IRQ14,15.
// - Bit 7 qualifies battery low and button, each gated by its misc enable.
// - Bit 6 qualifies external management input only with its system enable set.
// - Bits 5,4,3,1 qualify SMI output, NMI, INTR, serial ring indicate.
// - Master enable bit 0 clear ignores every system event source.
// - A qualified event reloads standby and SMI delay timers.
// - A qualified event sets the system event cause flag in global status.
`timescale 1ns/1ps
module pm_system_event_enable
    import pm_event_pkg::*;
(
    input  wire logic                            clock,
    input  wire logic                            rst_n,
    input  wire logic [pm_event_pkg::ADDR_W-1:0] address,
    input  wire logic                            read,
    input  wire logic                            write,
    input  wire logic [pm_event_pkg::DATA_W-1:0] writedata,
    input  wire logic [3:0]                      byteenable,
    output logic      [pm_event_pkg::DATA_W-1:0] readdata,
    output logic                                 waitrequest,
    input  wire pm_event_pkg::event_sources_type sources,
    input  wire logic                            disk_output_enable_n,
    input  wire logic                            rtc_addr_latch_enable,
    output logic [pm_event_pkg::NUM_GENERAL_OUTPUTS-1:0] general_outputs,
    output logic                                 standby_timer_reload,
    output logic                                 smi_delay_reload,
    output logic                                 resume_request,
    output logic                                 irq
);
    import pm_event_pkg::*;

    logic [REG_W-1:0]          resume_control_2;
    logic [REG_W-1:0]          general_output_control;
    logic [REG_W-1:0]          system_event_enable_0;
    logic [REG_W-1:0]          system_event_enable_1;
    logic [REG_W-1:0]          system_event_enable_2;
    logic [REG_W-1:0]          aux_control;
    logic                      system_event_cause_flag;
    logic [NUM_IRQ_EVENTS-1:0] irq_enable;
    logic [NUM_IRQ_EVENTS-1:0] irq_status;

    logic                      ack;
    logic                      bus_write;
    logic [IDX_W-1:0]          word_index;
    logic [REG_W-1:0]          wdata;
    logic [REG_W-1:0]          read_value;
    logic [REG_W-1:0]          next_general_output;

    logic [NUM_SOURCES-1:0]    activity;
    logic [NUM_SOURCES-1:0]    source_enable;
    logic [NUM_SOURCES-1:0]    qualified;
    logic [NUM_SOURCES-1:0]    qualified_rise;
    logic                      event_pulse;
    logic                      ext_mgmt_rise;
    logic                      resume_pulse;
    logic                      event_master_en;
    logic                      ext_mgmt_resume_mask;
    logic                      disk_oe_select;
    logic                      rtc_ale_select;

    // Bus slave: one wait cycle, then the access completes
    assign word_index  = address[ADDR_W-1:2];
    assign wdata       = writedata[REG_W-1:0];
    assign waitrequest = (read | write) & ~ack;
    assign bus_write   = write & ack & byteenable[0];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (read | write) & ~ack;
        end
    end

    always_comb begin
        unique case (word_index)
            RESUME_CONTROL_2_INDEX:       read_value = resume_control_2;
            GENERAL_OUTPUT_CONTROL_INDEX: read_value = general_output_control;
            SYSTEM_EVENT_ENABLE_0_INDEX:  read_value = system_event_enable_0;
            SYSTEM_EVENT_ENABLE_1_INDEX:  read_value = system_event_enable_1;
            SYSTEM_EVENT_ENABLE_2_INDEX:  read_value = system_event_enable_2;
            AUX_CONTROL_INDEX:            read_value = aux_control;
            GLOBAL_MGMT_IRQ_STATUS_INDEX: read_value = {system_event_cause_flag, 7'h00};
            IRQ_STATUS_INDEX:             read_value = {6'h00, irq_status};
            IRQ_ENABLE_INDEX:             read_value = {6'h00, irq_enable};
            default:                      read_value = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            readdata <= '0;
        end else if (read && !ack) begin
            readdata <= {{(DATA_W-REG_W){1'b0}}, read_value};
        end
    end

    // Control registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            resume_control_2      <= RESUME_CONTROL_2_RESET;
            system_event_enable_0 <= SYSTEM_EVENT_ENABLE_RESET;
            system_event_enable_1 <= SYSTEM_EVENT_ENABLE_RESET;
            system_event_enable_2 <= SYSTEM_EVENT_ENABLE_RESET;
            aux_control           <= AUX_CONTROL_RESET;
            irq_enable            <= '0;
        end else if (bus_write) begin
            if (word_index == RESUME_CONTROL_2_INDEX) begin
                resume_control_2 <= wdata & RESUME_CONTROL_2_BITS;
            end
            if (word_index == SYSTEM_EVENT_ENABLE_0_INDEX) begin
                system_event_enable_0 <= wdata & SYSTEM_EVENT_ENABLE_0_BITS;
            end
            if (word_index == SYSTEM_EVENT_ENABLE_1_INDEX) begin
                system_event_enable_1 <= wdata & SYSTEM_EVENT_ENABLE_1_BITS;
            end
            if (word_index == SYSTEM_EVENT_ENABLE_2_INDEX) begin
                system_event_enable_2 <= wdata & SYSTEM_EVENT_ENABLE_2_BITS;
            end
            if (word_index == AUX_CONTROL_INDEX) begin
                aux_control <= wdata & AUX_CONTROL_BITS;
            end
            if (word_index == IRQ_ENABLE_INDEX) begin
                irq_enable <= wdata[NUM_IRQ_EVENTS-1:0];
            end
        end
    end

    assign event_master_en      = system_event_enable_2[EVENT_MASTER_EN_BIT];
    assign ext_mgmt_resume_mask = resume_control_2[EXT_MGMT_RESUME_MASK_BIT];
    assign disk_oe_select       = aux_control[DISK_OE_SELECT_BIT];
    assign rtc_ale_select       = aux_control[RTC_ALE_SELECT_BIT];

    // General output control; bits owned by an alternate function keep their value
    always_comb begin
        next_general_output = wdata & GENERAL_OUTPUT_CONTROL_BITS;
        if (disk_oe_select) begin
            next_general_output[DISK_OUT_BIT] = general_output_control[DISK_OUT_BIT];
        end
        if (rtc_ale_select) begin
            next_general_output[RTC_ALE_BIT] = general_output_control[RTC_ALE_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            general_output_control <= GENERAL_OUTPUT_CONTROL_RESET;
        end else if (bus_write && word_index == GENERAL_OUTPUT_CONTROL_INDEX) begin
            general_output_control <= next_general_output;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            general_outputs <= GENERAL_OUTPUT_CONTROL_RESET[NUM_GENERAL_OUTPUTS-1:0];
        end else begin
            general_outputs <= general_output_control[NUM_GENERAL_OUTPUTS-1:0];
            if (disk_oe_select) begin
                general_outputs[DISK_OUT_BIT] <= disk_output_enable_n;
            end
            if (rtc_ale_select) begin
                general_outputs[RTC_ALE_BIT] <= rtc_addr_latch_enable;
            end
        end
    end

    // Source activity, all taken as active-high levels
    assign activity = {~sources.suspend_button_in_n, ~sources.battery_low_in_n,
                       ~sources.ext_mgmt_irq_in_n, ~sources.mgmt_irq_out_n,
                       sources.nmi, sources.intr, ~sources.serial_ring_indicate_n,
                       sources.irq_lines};

    // Per-source enables; reserved enable bits are stored as zero
    assign source_enable[7:0]          = system_event_enable_0;
    assign source_enable[12:8]         = system_event_enable_1[4:0];
    assign source_enable[13]           = system_event_enable_1[5];
    assign source_enable[15:14]        = system_event_enable_1[7:6];
    assign source_enable[SRC_SERIAL_RING_INDICATE]    = system_event_enable_2[SERIAL_RING_INDICATE_EVENT_EN_BIT];
    assign source_enable[SRC_INTR]     = system_event_enable_2[INTR_EVENT_EN_BIT];
    assign source_enable[SRC_NMI]      = system_event_enable_2[NMI_EVENT_EN_BIT];
    assign source_enable[SRC_SMI]      = system_event_enable_2[SMI_EVENT_EN_BIT];
    assign source_enable[SRC_EXT_MGMT] = system_event_enable_2[EXT_MGMT_EVENT_EN_BIT]
                                         & aux_control[SYSTEM_EXT_MGMT_EN_BIT];
    assign source_enable[SRC_BATTERY]  = system_event_enable_2[HW_SUSPEND_EVENT_EN_BIT]
                                         & aux_control[MISC_BATTERY_EN_BIT];
    assign source_enable[SRC_BUTTON]   = system_event_enable_2[HW_SUSPEND_EVENT_EN_BIT]
                                         & aux_control[MISC_BUTTON_EN_BIT];

    assign qualified = {NUM_SOURCES{event_master_en}} & source_enable & activity;

    rise_detect #(
        .WIDTH (NUM_SOURCES)
    ) qualified_edges (
        .clock (clock),
        .rst_n (rst_n),
        .level (qualified),
        .rise  (qualified_rise)
    );

    assign event_pulse = |qualified_rise;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            standby_timer_reload <= 1'b0;
            smi_delay_reload     <= 1'b0;
        end else begin
            standby_timer_reload <= event_pulse;
            smi_delay_reload     <= event_pulse;
        end
    end

    // Cause flag: hardware sets, writing zero clears, set wins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            system_event_cause_flag <= 1'b0;
        end else if (event_pulse) begin
            system_event_cause_flag <= 1'b1;
        end else if (bus_write && word_index == GLOBAL_MGMT_IRQ_STATUS_INDEX && !wdata[CAUSE_FLAG_BIT]) begin
            system_event_cause_flag <= 1'b0;
        end
    end

    // Resume request from the external management interrupt input
    rise_detect #(
        .WIDTH (1)
    ) ext_mgmt_edge (
        .clock (clock),
        .rst_n (rst_n),
        .level (~sources.ext_mgmt_irq_in_n),
        .rise  (ext_mgmt_rise)
    );

    assign resume_pulse = ext_mgmt_rise & ~ext_mgmt_resume_mask;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            resume_request <= 1'b0;
        end else begin
            resume_request <= resume_pulse;
        end
    end

    sticky_status #(
        .WIDTH (NUM_IRQ_EVENTS)
    ) irq_events (
        .clock      (clock),
        .rst_n      (rst_n),
        .set        ({resume_pulse, event_pulse}),
        .clear_we   (bus_write && word_index == IRQ_CLEAR_INDEX),
        .clear_bits (wdata[NUM_IRQ_EVENTS-1:0]),
        .enable     (irq_enable),
        .status     (irq_status),
        .irq        (irq)
    );

    // Assertions
    property p_resume_masked;
        @(posedge clock) disable iff (!rst_n)
        (ext_mgmt_rise && ext_mgmt_resume_mask) |=> !resume_request;
    endproperty
    a_resume_masked: assert property (p_resume_masked) else $error("masked input caused resume");

    property p_resume_unmasked;
        @(posedge clock) disable iff (!rst_n)
        (ext_mgmt_rise && !ext_mgmt_resume_mask) |=> resume_request;
    endproperty
    a_resume_unmasked: assert property (p_resume_unmasked) else $error("resume not requested");

    property p_output_follows;
        @(posedge clock) disable iff (!rst_n)
        !$fell(rst_n) ##1 1'b1 |-> general_outputs[3:0] == $past(general_output_control[3:0]);
    endproperty
    a_output_follows: assert property (p_output_follows) else $error("output pin does not follow control");

    property p_disk_pin_alt;
        @(posedge clock) disable iff (!rst_n)
        disk_oe_select |=> general_outputs[DISK_OUT_BIT] == $past(disk_output_enable_n);
    endproperty
    a_disk_pin_alt: assert property (p_disk_pin_alt) else $error("pin 5 not on alternate function");

    property p_disk_bit_kept;
        @(posedge clock) disable iff (!rst_n)
        (bus_write && word_index == GENERAL_OUTPUT_CONTROL_INDEX && disk_oe_select)
            |=> $stable(general_output_control[DISK_OUT_BIT]);
    endproperty
    a_disk_bit_kept: assert property (p_disk_bit_kept) else $error("bit 5 changed in alternate mode");

    property p_rtc_pin_alt;
        @(posedge clock) disable iff (!rst_n)
        rtc_ale_select |=> general_outputs[RTC_ALE_BIT] == $past(rtc_addr_latch_enable);
    endproperty
    a_rtc_pin_alt: assert property (p_rtc_pin_alt) else $error("pin 4 not on alternate function");

    property p_reserved_zero;
        @(posedge clock) disable iff (!rst_n)
        !system_event_enable_0[2] && !system_event_enable_1[5] && !source_enable[13];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved enable bit set");

    property p_master_off;
        @(posedge clock) disable iff (!rst_n)
        !event_master_en |=> !standby_timer_reload && !smi_delay_reload;
    endproperty
    a_master_off: assert property (p_master_off) else $error("reload with master enable off");

    property p_ext_gated;
        @(posedge clock) disable iff (!rst_n)
        !aux_control[SYSTEM_EXT_MGMT_EN_BIT] |-> !qualified[SRC_EXT_MGMT];
    endproperty
    a_ext_gated: assert property (p_ext_gated) else $error("external input qualified without enable");

    property p_reload_on_rise;
        @(posedge clock) disable iff (!rst_n)
        (qualified != '0 && $past(qualified) == '0) |=> standby_timer_reload && smi_delay_reload;
    endproperty
    a_reload_on_rise: assert property (p_reload_on_rise) else $error("qualified event not reloaded");

    property p_reload_single;
        @(posedge clock) disable iff (!rst_n)
        (qualified == $past(qualified)) |=> !standby_timer_reload;
    endproperty
    a_reload_single: assert property (p_reload_single) else $error("reload without new event");

    property p_cause_flag;
        @(posedge clock) disable iff (!rst_n)
        standby_timer_reload |-> system_event_cause_flag;
    endproperty
    a_cause_flag: assert property (p_cause_flag) else $error("cause flag missing");

    c_reload: cover property (@(posedge clock) disable iff (!rst_n) standby_timer_reload);
    c_resume: cover property (@(posedge clock) disable iff (!rst_n) resume_request);
    c_irq: cover property (@(posedge clock) disable iff (!rst_n) irq);
    c_alt_write: cover property (@(posedge clock) disable iff (!rst_n)
        bus_write && word_index == GENERAL_OUTPUT_CONTROL_INDEX && disk_oe_select);
endmodule // pm_system_event_enable

/* File: verification/pm_system_event_enable_tb.sv */
/* Self-checking bench for the power-management event enable block.
   Assumes an Avalon-MM slave that ends each request by dropping waitrequest. */
`timescale 1ns/1ps
module pm_system_event_enable_tb;
    import pm_event_pkg::*;
    logic                     clock = 0, rst_n = 0, read = 0, write = 0, dis = 1, rtc = 0, irq;
    logic [ADDR_W-1:0]        address = '0;
    logic [DATA_W-1:0]        writedata = '0, readdata;
    logic                     waitrequest, rl, sd, rs;
    logic [5:0]               go;
    event_sources_type        src = 23'h1f;
    logic [7:0]               q;
    int                       n_fail = 0, checks_done = 0, cyc = 0, n_rl = 0, n_sd = 0, n_rs = 0;

    pm_system_event_enable i_dut (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
        .waitrequest(waitrequest), .sources(src), .disk_output_enable_n(dis),
        .rtc_addr_latch_enable(rtc), .general_outputs(go), .standby_timer_reload(rl),
        .smi_delay_reload(sd), .resume_request(rs), .irq(irq));

    always #25 clock = ~clock;
    always @(posedge clock) begin
        n_rl += (rl === 1'b1);
        n_sd += (sd === 1'b1);
        n_rs += (rs === 1'b1);
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            test_done;
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Avalon access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge clock);
        address <= {i, 2'b00};
        read <= !w;
        write <= w;
        writedata <= {24'h0, d};
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] i, input logic [7:0] exp);
        acc(1'b0, i, 8'h00);
        chk(q, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    // Activity pulse; result packs reload count above resume count
    task automatic pulse(input logic [22:0] v, input logic [7:0] exp);
        int b1, b2;
        b1 = n_rl;
        b2 = n_rs;
        @(posedge clock) src <= v;
        repeat (4) @(posedge clock);
        src <= 23'h1f;
        settle(3);
        chk({4'(n_rl - b1), 4'(n_rs - b2)}, exp);
    endtask

    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rchk(8'hcd, 8'h00);
        rchk(8'hce, 8'h3f);
        rchk(8'hd0, 8'h00);
        rchk(8'hd2, 8'h00);
        chk(8'(go), 8'h3f);
        $display("reset test done");
        acc(1'b1, 8'hce, 8'hea);
        settle(2);
        chk(8'(go), 8'h2a);
        acc(1'b1, 8'hd0, 8'hff);
        acc(1'b1, 8'hd1, 8'hff);
        acc(1'b1, 8'hd2, 8'hff);
        acc(1'b1, 8'hcd, 8'hff);
        rchk(8'hd0, 8'hfb);
        rchk(8'hd1, 8'hdf);
        rchk(8'hd2, 8'hfb);
        rchk(8'hcd, 8'h01);
        $display("register test done");
        acc(1'b1, 8'hf0, 8'h1f);
        dis <= 1'b0;
        rtc <= 1'b1;
        acc(1'b1, 8'hce, 8'h00);
        settle(3);
        chk(8'(go), 8'h10);
        dis <= 1'b1;
        rtc <= 1'b0;
        settle(3);
        chk(8'(go), 8'h20);
        $display("output pin test done");
        pulse(23'h1f | 23'h1 << 10, 8'h10);
        pulse(23'h1f | 23'h1 << 9, 8'h00);
        pulse(23'h1f | 23'h1 << 20, 8'h00);
        pulse(23'h1f | 23'h1 << 21, 8'h10);
        pulse(23'h1b, 8'h10);
        pulse(23'h1f | 23'h1 << 6, 8'h10);
        pulse(23'h17, 8'h10);
        pulse(23'h1e, 8'h10);
        pulse(23'h1f | 23'h1 << 5, 8'h10);
        pulse(23'h0f, 8'h10);
        pulse(23'h1d, 8'h10);
        acc(1'b1, 8'hf0, 8'h03);
        pulse(23'h17, 8'h00);
        pulse(23'h19, 8'h00);
        acc(1'b1, 8'hd2, 8'hfa);
        pulse(23'h1f | 23'h1 << 10, 8'h00);
        acc(1'b1, 8'hcd, 8'h00);
        pulse(23'h17, 8'h01);
        chk(8'(n_sd), 8'(n_rl));
        rchk(8'hf1, 8'h80);
        $display("event test done");
        rchk(8'hf2, 8'h03);
        acc(1'b1, 8'hf4, 8'h01);
        settle(1);
        chk(8'(irq), 8'h01);
        acc(1'b1, 8'hf3, 8'h01);
        settle(1);
        chk(8'(irq), 8'h00);
        rchk(8'hf2, 8'h02);
        rchk(8'h00, 8'h00);
        $display("interrupt test done");
        test_done;
    end
endmodule // pm_system_event_enable_tb
